// file: src/umfc_top.sv
//Contract
// - Delta CTS/DSR set on toggle since read
// - Modem interrupt while any change flag set
// - Eight-bit scratch store, read back unchanged
// - Auto CTS: high CTS halts transmit
// - Auto RTS: interrupt at trigger, RTS off next
// - Auto RTS: RTS back below lower trigger
// - Without auto RTS, pin follows modem control
// - Auto RTS bit reads flow control status
// - Special character: match second pause, flag
// - Character bit zero meets received LSB
// - Enhanced fields writable only when enabled
// - Clearing enhanced enable freezes those fields
// - Low four bits pick software flow, reset zero
// - Dual modes treat character pairs as sequence
// - Feature bits all reset to zero
// - Bits 3:2 transmit pairs, 1:0 receive pairs
// - Reset clears change flags, upper bits live
// - Character in progress finishes before halt
`timescale 1ns/1ps
`default_nettype none
module umfc_top #(
  parameter int LVL_W = 7
) (
  input  wire logic             CLK_I,
  input  wire logic             RST_B_I,
  input  wire logic [3:0]       ADDR_I,
  input  wire logic [7:0]       WDATA_I,
  input  wire logic             WR_I,
  input  wire logic             RD_I,
  output logic      [7:0]       RDATA_O,
  input  wire logic             CTS_B_I,
  input  wire logic             DSR_B_I,
  input  wire logic             CD_B_I,
  input  wire logic             RI_B_I,
  input  wire logic             RX_VALID_I,
  input  wire logic [7:0]       RX_DATA_I,
  input  wire logic [LVL_W-1:0] RX_LEVEL_I,
  input  wire logic             FLOW_CHAR_ACK_I,
  output logic      [7:0]       FLOW_CHAR_O,
  output logic                  FLOW_CHAR_VLD_O,
  output logic                  TX_GO_O,
  output logic                  RTS_B_O,
  output logic                  MODEM_INT_O,
  output logic                  INT_O
);
  logic [7:0] scr_q, feat_q, mask_q, fifo_q, mout_q;
  logic [7:0] res1_q, res2_q, pau1_q, pau2_q;
  logic [1:0] dlt_q;
  logic       cts_prev_q, dsr_prev_q, live_q;
  logic       spch_q, paused_q, sw_halt_q;
  logic [7:0] stat_v, feat_rd, cause_v, rd_v;
  logic [LVL_W-1:0] trig, nxt, low;
  logic       wr_enh, msint, rx_int, pause_set, pause_clr, stat_rd;
  umfc_pkg::umfc_snd_t snd_q;
  logic       snd_off_q;

  assign wr_enh = feat_q[umfc_pkg::FEAT_ENH];

  // ==========================================
  // Register writes
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      scr_q  <= umfc_pkg::REG_RST;
      feat_q <= umfc_pkg::REG_RST;
      res1_q <= umfc_pkg::REG_RST;
      res2_q <= umfc_pkg::REG_RST;
      pau1_q <= umfc_pkg::REG_RST;
      pau2_q <= umfc_pkg::REG_RST;
    end else if (WR_I) begin
      case (ADDR_I)
        umfc_pkg::A_SCR:  scr_q  <= WDATA_I;
        umfc_pkg::A_FEAT: feat_q <= WDATA_I;
        umfc_pkg::A_RES1: res1_q <= WDATA_I;
        umfc_pkg::A_RES2: res2_q <= WDATA_I;
        umfc_pkg::A_PAU1: pau1_q <= WDATA_I;
        umfc_pkg::A_PAU2: pau2_q <= WDATA_I;
        default: ;
      endcase
    end
  end

  // Enhanced bits keep their value unless the enable bit is set
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] msk,
                                       input logic       en);
    logic [7:0] m;
    m = en ? 8'hFF : ~msk;
    return (WDATA_I & m) | (old & ~m);
  endfunction : merge

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mask_q <= umfc_pkg::REG_RST;
      fifo_q <= umfc_pkg::REG_RST;
      mout_q <= umfc_pkg::REG_RST;
    end else if (WR_I) begin
      if (ADDR_I == umfc_pkg::A_MASK) begin
        mask_q <= merge(mask_q, umfc_pkg::MASK_ENH, wr_enh);
      end
      if (ADDR_I == umfc_pkg::A_FIFO) begin
        fifo_q <= merge(fifo_q, umfc_pkg::FIFO_ENH, wr_enh);
      end
      if (ADDR_I == umfc_pkg::A_MOUT) begin
        mout_q <= merge(mout_q, umfc_pkg::MOUT_ENH, wr_enh);
      end
    end
  end

  // ==========================================
  // Modem change detection
  // Previous levels are caught one edge after release, not under reset
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      live_q     <= 1'b0;
      cts_prev_q <= 1'b0;
      dsr_prev_q <= 1'b0;
      dlt_q      <= 2'b00;
    end else begin
      live_q     <= 1'b1;
      cts_prev_q <= CTS_B_I;
      dsr_prev_q <= DSR_B_I;
      // A toggle in the read cycle survives the clear
      dlt_q[umfc_pkg::STAT_DCTS] <= (live_q & (CTS_B_I ^ cts_prev_q))
        | (dlt_q[umfc_pkg::STAT_DCTS] & ~stat_rd);
      dlt_q[umfc_pkg::STAT_DDSR] <= (live_q & (DSR_B_I ^ dsr_prev_q))
        | (dlt_q[umfc_pkg::STAT_DDSR] & ~stat_rd);
    end
  end

  assign stat_rd = RD_I & (ADDR_I == umfc_pkg::A_STAT);
  // Upper bits show the inverted pins directly
  assign stat_v = {~CD_B_I, ~RI_B_I, ~DSR_B_I, ~CTS_B_I, 2'b00, dlt_q};
  assign msint = |stat_v[3:0];

  // ==========================================
  // Special character detect
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      spch_q <= 1'b0;
    end else begin
      spch_q <= (RX_VALID_I & feat_q[umfc_pkg::FEAT_SPCH] & (RX_DATA_I == pau2_q))
        | (spch_q & ~(RD_I & (ADDR_I == umfc_pkg::A_CAUSE)));
    end
  end

  // ==========================================
  // Trigger levels and automatic RTS
  function automatic logic [LVL_W-1:0] lvl(input logic [1:0] i);
    case (i)
      2'd0:    lvl = LVL_W'(umfc_pkg::TRIG_0);
      2'd1:    lvl = LVL_W'(umfc_pkg::TRIG_1);
      2'd2:    lvl = LVL_W'(umfc_pkg::TRIG_2);
      default: lvl = LVL_W'(umfc_pkg::TRIG_3);
    endcase
  endfunction : lvl

  logic [1:0] ti;
  assign ti   = fifo_q[7:6];
  assign trig = lvl(ti);
  // Top level has no higher step, bottom none lower
  assign nxt  = lvl((ti == 2'd3) ? ti : ti + 2'd1);
  assign low  = lvl((ti == 2'd0) ? ti : ti - 2'd1);
  assign rx_int    = (RX_LEVEL_I >= trig);
  assign pause_set = (RX_LEVEL_I >= nxt);
  assign pause_clr = (RX_LEVEL_I < low);

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      paused_q <= 1'b0;
    end else if (pause_set) begin
      paused_q <= 1'b1;
    end else if (pause_clr) begin
      paused_q <= 1'b0;
    end
  end

  // ==========================================
  // Receive side software flow: pause/resume pair matchers
  umfc_match_if mp ();
  umfc_match_if mr ();
  assign mp.c1       = pau1_q;
  assign mp.c2       = pau2_q;
  assign mr.c1       = res1_q;
  assign mr.c2       = res2_q;
  assign mp.rx_data  = RX_DATA_I;
  assign mr.rx_data  = RX_DATA_I;
  assign mp.rx_valid = RX_VALID_I;
  assign mr.rx_valid = RX_VALID_I;
  assign mp.mode     = feat_q[1:0];
  assign mr.mode     = feat_q[1:0];

  umfc_match u_pause (.clk_i(CLK_I), .rst_b_i(RST_B_I), .m(mp.mat));
  umfc_match u_resume (.clk_i(CLK_I), .rst_b_i(RST_B_I), .m(mr.mat));

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sw_halt_q <= 1'b0;
    end else if (feat_q[1:0] == 2'b00) begin
      sw_halt_q <= 1'b0;
    end else if (mp.hit) begin
      sw_halt_q <= 1'b1;
    end else if (mr.hit) begin
      sw_halt_q <= 1'b0;
    end
  end

  // ==========================================
  // Transmit side software flow: send pause or resume chars
  logic paused_d1_q;
  logic [1:0] txm;
  assign txm = feat_q[3:2];
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      paused_d1_q     <= 1'b0;
      snd_q           <= umfc_pkg::SND_IDLE;
      snd_off_q       <= 1'b0;
      FLOW_CHAR_VLD_O <= 1'b0;
      FLOW_CHAR_O     <= 8'h00;
    end else begin
      paused_d1_q <= paused_q;
      case (snd_q)
        umfc_pkg::SND_IDLE: begin
          if ((paused_q != paused_d1_q) && (txm != 2'b00)) begin
            snd_off_q       <= paused_q;
            FLOW_CHAR_VLD_O <= 1'b1;
            if (txm[1]) begin
              snd_q       <= umfc_pkg::SND_FIRST;
              FLOW_CHAR_O <= paused_q ? pau1_q : res1_q;
            end else begin
              snd_q       <= umfc_pkg::SND_SECOND;
              FLOW_CHAR_O <= paused_q ? pau2_q : res2_q;
            end
          end
        end
        umfc_pkg::SND_FIRST: begin
          if (FLOW_CHAR_ACK_I) begin
            if (txm[0]) begin
              snd_q       <= umfc_pkg::SND_SECOND;
              FLOW_CHAR_O <= snd_off_q ? pau2_q : res2_q;
            end else begin
              snd_q           <= umfc_pkg::SND_IDLE;
              FLOW_CHAR_VLD_O <= 1'b0;
            end
          end
        end
        umfc_pkg::SND_SECOND: begin
          if (FLOW_CHAR_ACK_I) begin
            snd_q           <= umfc_pkg::SND_IDLE;
            FLOW_CHAR_VLD_O <= 1'b0;
          end
        end
        default: begin
          snd_q           <= umfc_pkg::SND_IDLE;
          FLOW_CHAR_VLD_O <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // Pin and interrupt outputs
  // Gate only the start of a character; one in flight still ends
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      TX_GO_O <= 1'b1;
      RTS_B_O <= 1'b1;
    end else begin
      TX_GO_O <= ~(feat_q[umfc_pkg::FEAT_ACTS] & CTS_B_I) & ~sw_halt_q;
      if (feat_q[umfc_pkg::FEAT_ARTS]) begin
        RTS_B_O <= paused_q | ~mout_q[umfc_pkg::MOUT_RTS];
      end else begin
        RTS_B_O <= ~mout_q[umfc_pkg::MOUT_RTS];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      MODEM_INT_O <= 1'b0;
      INT_O       <= 1'b0;
    end else begin
      MODEM_INT_O <= msint;
      INT_O <= (mask_q[umfc_pkg::MASK_MS] & msint) | (mask_q[umfc_pkg::MASK_RX] & rx_int)
        | (mask_q[umfc_pkg::MASK_SPCH] & spch_q);
    end
  end

  // ==========================================
  // Read path
  // Auto RTS bit reads one only while enabled and RTS not held off
  always_comb begin
    feat_rd = feat_q;
    feat_rd[umfc_pkg::FEAT_ARTS] = feat_q[umfc_pkg::FEAT_ARTS] & ~paused_q;
    cause_v = {2'b00, 1'b0, spch_q, 3'b000, ~INT_O};
    case (ADDR_I)
      umfc_pkg::A_STAT:  rd_v = stat_v;
      umfc_pkg::A_SCR:   rd_v = scr_q;
      umfc_pkg::A_FEAT:  rd_v = feat_rd;
      umfc_pkg::A_MASK:  rd_v = mask_q;
      umfc_pkg::A_CAUSE: rd_v = cause_v;
      umfc_pkg::A_FIFO:  rd_v = fifo_q;
      umfc_pkg::A_MOUT:  rd_v = mout_q;
      umfc_pkg::A_RES1:  rd_v = res1_q;
      umfc_pkg::A_RES2:  rd_v = res2_q;
      umfc_pkg::A_PAU1:  rd_v = pau1_q;
      umfc_pkg::A_PAU2:  rd_v = pau2_q;
      default:           rd_v = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= 8'h00;
    end else begin
      RDATA_O <= RD_I ? rd_v : 8'h00;
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_cts_toggle;
    live_q && (CTS_B_I != cts_prev_q);
  endsequence
  sequence s_stat_read;
    RD_I && ADDR_I == umfc_pkg::A_STAT;
  endsequence
  sequence s_scratch_rd;
    RD_I && ADDR_I == umfc_pkg::A_SCR && !WR_I;
  endsequence

  a_dcts_set: assert property (s_cts_toggle |=> dlt_q[0])
    else $error("cts change flag missed");
  a_dcts_clear: assert property (
    s_stat_read ##0 (!live_q || CTS_B_I == cts_prev_q) |=> !dlt_q[0])
    else $error("cts change flag not cleared by read");
  a_modem_irq: assert property (|dlt_q |=> MODEM_INT_O)
    else $error("modem interrupt missing");
  // Host leaves one idle cycle between the write and the read back
  a_scratch_back: assert property (
    WR_I && ADDR_I == umfc_pkg::A_SCR ##1 !WR_I ##1 s_scratch_rd
    |=> RDATA_O == $past(WDATA_I, 3))
    else $error("scratch readback wrong");
  a_cts_halt: assert property (feat_q[7] && CTS_B_I |=> !TX_GO_O)
    else $error("transmit not halted by cts");
  a_rts_raise: assert property (feat_q[6] && pause_set ##1 feat_q[6] |=> RTS_B_O)
    else $error("rts not raised at next trigger");
  a_rts_drop: assert property (paused_q && pause_clr && !pause_set |=> !paused_q)
    else $error("rts hold not released");
  a_rts_plain: assert property (!feat_q[6] |=> RTS_B_O == !$past(mout_q[1]))
    else $error("rts not following control bit");
  a_spch_flag: assert property (
    RX_VALID_I && feat_q[5] && RX_DATA_I == pau2_q |=> spch_q)
    else $error("special character not flagged");
  a_enh_frozen: assert property (
    WR_I && ADDR_I == umfc_pkg::A_MASK && !wr_enh |=> mask_q[7:4] == $past(mask_q[7:4]))
    else $error("enhanced field changed while locked");
endmodule : umfc_top
`default_nettype wire

// file: src/umfc_pkg.sv
`default_nettype none
package umfc_pkg;
  // ==========================================
  // Register indices (one per address)
  localparam logic [3:0] A_STAT  = 4'h0;
  localparam logic [3:0] A_SCR   = 4'h1;
  localparam logic [3:0] A_FEAT  = 4'h2;
  localparam logic [3:0] A_MASK  = 4'h3;
  localparam logic [3:0] A_CAUSE = 4'h4;
  localparam logic [3:0] A_FIFO  = 4'h5;
  localparam logic [3:0] A_MOUT  = 4'h6;
  localparam logic [3:0] A_RES1  = 4'h7;
  localparam logic [3:0] A_RES2  = 4'h8;
  localparam logic [3:0] A_PAU1  = 4'h9;
  localparam logic [3:0] A_PAU2  = 4'hA;
  // ==========================================
  // Field positions
  localparam int FEAT_ACTS  = 7;
  localparam int FEAT_ARTS  = 6;
  localparam int FEAT_SPCH  = 5;
  localparam int FEAT_ENH   = 4;
  localparam int STAT_DCTS  = 0;
  localparam int STAT_DDSR  = 1;
  localparam int CAUSE_SPCH = 4;
  localparam int MOUT_RTS   = 1;
  localparam int MASK_RX    = 0;
  localparam int MASK_MS    = 3;
  localparam int MASK_SPCH  = 5;
  // ==========================================
  // Protected enhanced fields and reset values
  localparam logic [7:0] MASK_ENH  = 8'hF0;
  localparam logic [7:0] FIFO_ENH  = 8'h30;
  localparam logic [7:0] MOUT_ENH  = 8'hE0;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] CAUSE_RST = 8'h01;
  // ==========================================
  // Receive FIFO trigger levels, picked by the two top setup bits
  localparam logic [6:0] TRIG_0 = 7'h08;
  localparam logic [6:0] TRIG_1 = 7'h10;
  localparam logic [6:0] TRIG_2 = 7'h38;
  localparam logic [6:0] TRIG_3 = 7'h3C;
  typedef enum logic [1:0] {
    SND_IDLE   = 2'b00,
    SND_FIRST  = 2'b01,
    SND_SECOND = 2'b11
  } umfc_snd_t;
endpackage : umfc_pkg
`default_nettype wire

// file: src/umfc_match_if.sv
`timescale 1ns/1ps
`default_nettype none
interface umfc_match_if;
  logic [7:0] c1;
  logic [7:0] c2;
  logic [7:0] rx_data;
  logic [1:0] mode;
  logic       rx_valid;
  logic       hit;
  modport ctl (output c1, c2, rx_data, mode, rx_valid, input hit);
  modport mat (input c1, c2, rx_data, mode, rx_valid, output hit);
endinterface : umfc_match_if
`default_nettype wire

// file: src/umfc_match.sv
`timescale 1ns/1ps
`default_nettype none
module umfc_match (
  input  wire logic   clk_i,
  input  wire logic   rst_b_i,
  umfc_match_if.mat   m
);
  logic hit_q;
  logic half_q;
  logic eq1;
  logic eq2;
  // Bit 0 of each character register meets bit 0 of the received byte
  assign eq1 = (m.rx_data == m.c1);
  assign eq2 = (m.rx_data == m.c2);
  assign m.hit = hit_q;

  // ==========================================
  // Single or two-character sequence match
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hit_q  <= 1'b0;
      half_q <= 1'b0;
    end else begin
      case (m.mode)
        2'b10:   hit_q <= m.rx_valid & eq1;
        2'b01:   hit_q <= m.rx_valid & eq2;
        2'b11:   hit_q <= m.rx_valid & half_q & eq2;
        default: hit_q <= 1'b0;
      endcase
      // Any other byte between the two breaks the sequence
      if (m.rx_valid) begin
        half_q <= eq1;
      end
    end
  end

  // Second character arriving while the first is still pending
  sequence s_pair_second;
    m.mode == 2'b11 && m.rx_valid && half_q && eq2;
  endsequence
  a_pair_hit_done: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    s_pair_second |=> hit_q)
    else $error("pair match not reported");
  a_pair_hit_order: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (m.mode == 2'b11 && m.rx_valid && !(half_q && eq2)) |=> !hit_q)
    else $error("pair hit without first character");
endmodule : umfc_match
`default_nettype wire

// file: bench/umfc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Remote side: modem pins and the transmitter taking flow characters
module umfc_far_end (
  input  wire logic       clk_i,
  input  wire logic [7:0] char_i,
  input  wire logic       vld_i,
  output logic            ack_o,
  output logic            cts_b_o,
  output logic            dsr_b_o
);
  int         gap;
  int         cnt;
  logic [7:0] got_q[$];
  initial begin
    ack_o = 1'b0;
    cts_b_o = 1'b1;
    dsr_b_o = 1'b1;
    gap = 0;
    cnt = 0;
  end
  // One-cycle ack, never two in a row, so each character is taken once
  always @(posedge clk_i) begin
    if (ack_o) begin
      ack_o <= 1'b0;
    end else if (vld_i && cnt >= gap) begin
      ack_o <= 1'b1;
      got_q.push_back(char_i);
      cnt <= 0;
    end else if (vld_i) begin
      cnt <= cnt + 1;
    end
  end
  task automatic set_pins(input logic cts, input logic dsr);
    @(posedge clk_i);
    cts_b_o <= cts;
    dsr_b_o <= dsr;
  endtask : set_pins
endmodule : umfc_far_end
`default_nettype wire

// file: bench/umfc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module umfc_top_bench;
  typedef struct packed {logic [7:0] e; logic [7:0] m;} umfc_note_t;
  localparam logic [3:0] R_STAT = 4'h0;
  localparam logic [3:0] R_SCR  = 4'h1;
  localparam logic [3:0] R_FEAT = 4'h2;
  localparam logic [3:0] R_MASK = 4'h3;
  localparam logic [3:0] R_CAUS = 4'h4;
  localparam logic [3:0] R_FIFO = 4'h5;
  localparam logic [3:0] R_MOUT = 4'h6;
  localparam logic [3:0] R_RES1 = 4'h7;
  localparam logic [3:0] R_PAU1 = 4'h9;
  logic       clk, rst_b, wr_s, rd_s, rd_seen, rx_vld, cd_b, ri_b;
  logic [3:0] adr;
  logic [7:0] wdat, rx_dat, v, pa, sc;
  logic [6:0] lvl;
  wire  [7:0] rdata, fchar;
  wire        cts_b, dsr_b, ack, fvld, tx_go, rts_b, mint, intr;
  umfc_note_t notes[$];
  umfc_note_t nt;
  logic [7:0] exp_q[$];
  int         n_fail, cmp_count;
  umfc_top i_umfc_top (.CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(adr), .WDATA_I(wdat),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .CTS_B_I(cts_b), .DSR_B_I(dsr_b),
    .CD_B_I(cd_b), .RI_B_I(ri_b), .RX_VALID_I(rx_vld), .RX_DATA_I(rx_dat),
    .RX_LEVEL_I(lvl), .FLOW_CHAR_ACK_I(ack), .FLOW_CHAR_O(fchar),
    .FLOW_CHAR_VLD_O(fvld), .TX_GO_O(tx_go), .RTS_B_O(rts_b), .MODEM_INT_O(mint),
    .INT_O(intr));
  umfc_far_end i_umfc_far_end (.clk_i(clk), .char_i(fchar), .vld_i(fvld), .ack_o(ack),
    .cts_b_o(cts_b), .dsr_b_o(dsr_b));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================
  // Checking
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: level %b expected %b", $time, got, exp);
    end
  endtask : cmp1
  always @(posedge clk) rd_seen <= rd_s;
  always @(negedge clk) begin
    if (rd_seen) begin
      nt = notes.pop_front();
      cmp8(rdata & nt.m, nt.e & nt.m);
    end
  end
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // ==========================================
  // Driving
  // Ends off the edge, so levels read next are settled ones
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    notes.push_back('{e, m});
    @(posedge clk);
    adr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
  endtask : rd
  task automatic rxc(input logic [7:0] ch);
    @(posedge clk);
    rx_vld <= 1'b1;
    rx_dat <= ch;
    @(posedge clk);
    rx_vld <= 1'b0;
    tick(3);
  endtask : rxc
  task automatic lvl_set(input logic [6:0] l);
    @(posedge clk);
    lvl <= l;
    tick(4);
  endtask : lvl_set
  initial begin
    #200000;
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    rst_b = 1'b0;
    adr = 4'h0;
    wdat = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    rx_vld = 1'b0;
    rx_dat = 8'h00;
    cd_b = 1'b1;
    ri_b = 1'b1;
    lvl = 7'h00;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(32'h58d9));
    tick(2);
    rst_b <= 1'b1;
    tick(2);
    cmp1(tx_go, 1'b1);
    rd(R_STAT, 8'h00, 8'hFF);
    rd(R_FEAT, 8'h00, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      wr(R_SCR, v);
      rd(R_SCR, v, 8'hFF);
    end
    rd(R_FEAT, 8'h00, 8'hFF);
    rd(4'hF, 8'h00, 8'hFF);
    wr(R_MASK, 8'hFF);
    rd(R_MASK, 8'h0F, 8'hFF);
    wr(R_FEAT, 8'h10);
    wr(R_MASK, 8'hFF);
    rd(R_MASK, 8'hFF, 8'hFF);
    wr(R_FEAT, 8'h00);
    wr(R_MASK, 8'h09);
    rd(R_MASK, 8'hF9, 8'hFF);
    wr(R_MOUT, 8'hE2);
    rd(R_MOUT, 8'h02, 8'hFF);
    tick(2);
    cmp1(rts_b, 1'b0);
    i_umfc_far_end.set_pins(1'b0, 1'b1);
    tick(3);
    cmp1(mint, 1'b1);
    cmp1(intr, 1'b1);
    rd(R_STAT, 8'h11, 8'hFF);
    rd(R_STAT, 8'h10, 8'hFF);
    tick(2);
    cmp1(mint, 1'b0);
    i_umfc_far_end.set_pins(1'b1, 1'b0);
    tick(3);
    rd(R_STAT, 8'h23, 8'hFF);
    i_umfc_far_end.set_pins(1'b1, 1'b1);
    tick(3);
    rd(R_STAT, 8'h02, 8'hFF);
    rd(R_STAT, 8'h00, 8'hFF);
    wr(R_FEAT, 8'h80);
    tick(3);
    cmp1(tx_go, 1'b0);
    i_umfc_far_end.set_pins(1'b0, 1'b1);
    tick(3);
    cmp1(tx_go, 1'b1);
    i_umfc_far_end.set_pins(1'b1, 1'b1);
    tick(3);
    cmp1(tx_go, 1'b0);
    wr(R_FEAT, 8'h00);
    tick(3);
    cmp1(tx_go, 1'b1);
    rd(R_STAT, 8'h00, 8'hF0);
    cd_b <= 1'b0;
    ri_b <= 1'b0;
    rd(R_STAT, 8'hC0, 8'hF0);
    cd_b <= 1'b1;
    ri_b <= 1'b1;
    // Trigger 8, next 16
    wr(R_FIFO, 8'h00);
    wr(R_FEAT, 8'h40);
    rd(R_FEAT, 8'h40, 8'hFF);
    lvl_set(7'h07);
    cmp1(intr, 1'b0);
    lvl_set(7'h08);
    cmp1(intr, 1'b1);
    cmp1(rts_b, 1'b0);
    lvl_set(7'h10);
    cmp1(rts_b, 1'b1);
    rd(R_FEAT, 8'h00, 8'hFF);
    lvl_set(7'h0C);
    cmp1(rts_b, 1'b1);
    lvl_set(7'h07);
    cmp1(rts_b, 1'b0);
    rd(R_FEAT, 8'h40, 8'hFF);
    wr(R_FEAT, 8'h00);
    lvl_set(7'h14);
    cmp1(rts_b, 1'b0);
    lvl_set(7'h00);
    // Flow characters kept distinct from every payload byte
    pa = $urandom;
    for (int i = 0; i < 4; i++) wr(R_RES1 + 4'(i), pa ^ (8'h01 << i));
    for (int m = 1; m < 4; m++) begin
      wr(R_FEAT, {4'h0, 2'(m), 2'b00});
      i_umfc_far_end.gap = (m == 2) ? 6 : 0;
      i_umfc_far_end.got_q.delete();
      exp_q.delete();
      if (m[1]) exp_q.push_back(pa ^ 8'h04);
      if (m[0]) exp_q.push_back(pa ^ 8'h08);
      if (m[1]) exp_q.push_back(pa ^ 8'h01);
      if (m[0]) exp_q.push_back(pa ^ 8'h02);
      lvl_set(7'h10);
      tick(30);
      lvl_set(7'h00);
      tick(30);
      cmp8(8'(i_umfc_far_end.got_q.size()), 8'(exp_q.size()));
      foreach (exp_q[k]) cmp8(i_umfc_far_end.got_q[k], exp_q[k]);
    end
    for (int m = 1; m < 4; m++) begin
      wr(R_FEAT, {6'h00, 2'(m)});
      if (m == 3) begin
        rxc(pa ^ 8'h04);
        rxc(pa ^ 8'h80);
        rxc(pa ^ 8'h08);
        cmp1(tx_go, 1'b1);
      end
      if (m[1]) rxc(pa ^ 8'h04);
      if (m[0]) rxc(pa ^ 8'h08);
      cmp1(tx_go, 1'b0);
      if (m[1]) rxc(pa ^ 8'h01);
      if (m[0]) rxc(pa ^ 8'h02);
      cmp1(tx_go, 1'b1);
    end
    sc = $urandom;
    wr(4'hA, sc);
    wr(R_FEAT, 8'h20);
    rxc(sc ^ 8'h01);
    rd(R_CAUS, 8'h00, 8'h10);
    rxc(sc);
    cmp1(intr, 1'b1);
    rd(R_CAUS, 8'h10, 8'h11);
    rd(R_CAUS, 8'h00, 8'h10);
    tick(3);
    stop_test();
  end
endmodule : umfc_top_bench
`default_nettype wire
